// >>> nvscp_pkg.sv
// shared constants and types for the power-up settings command parser
package nvscp_pkg;
   // ==================================================
   // packet geometry
   localparam int PKT_LEN = 64;          // bytes per command and response
   localparam int IDX_W = 7;             // index width, counts 0..64
   // ==================================================
   // command, sub-command and status codes
   localparam logic [7:0] CMD_SET_NV = 8'h60;
   localparam logic [7:0] SUB_SPI = 8'h10;
   localparam logic [7:0] SUB_CHIP = 8'h20;
   localparam logic [7:0] SUB_KEY = 8'h30;
   localparam logic [7:0] SUB_PROD = 8'h40;
   localparam logic [7:0] SUB_MFR = 8'h50;
   localparam logic [7:0] STS_OK = 8'h00;
   localparam logic [7:0] STS_BLOCKED = 8'hfb;
   localparam logic [7:0] STS_BUSY = 8'hf8;
   localparam logic [7:0] STS_UNSUPP = 8'hf7;   // unknown command or sub-command
   localparam logic [7:0] ACC_PW = 8'h40;
   localparam logic [7:0] ACC_LOCK = 8'h80;
   localparam logic [7:0] POWER_MASK = 8'he0;   // low five bits reserved
   // ==================================================
   // byte positions inside a command packet
   localparam int IX_CMD = 0;
   localparam int IX_SUB = 1;
   localparam int IX_ECHO = 2;
   localparam int IX_RATE = 4;
   localparam int IX_IDLE = 8;
   localparam int IX_ACT = 10;
   localparam int IX_PRE = 12;
   localparam int IX_POST = 14;
   localparam int IX_GAP = 16;
   localparam int IX_COUNT = 18;
   localparam int IX_MODE = 20;
   localparam int IX_VID = 4;
   localparam int IX_PID = 6;
   localparam int IX_POWER = 8;
   localparam int IX_CURR = 9;
   localparam int IX_ACCESS = 18;
   localparam int IX_PW = 19;
   localparam int PW_LEN = 8;
   localparam logic [6:0] IX_STR = 7'h04;       // first descriptor byte
   localparam logic [6:0] IX_LAST = 7'h3f;
   // delays are kept as raw counts of this unit, in microseconds
   localparam int DELAY_UNIT_US = 100;
   // ==================================================
   // values after reset
   localparam logic [31:0] RST_RATE = 32'h0000_0000;
   localparam logic [8:0] RST_CS = 9'h000;
   localparam logic [15:0] RST_HALF = 16'h0000;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [63:0] RST_PW = 64'h0;
   // ==================================================
   // parser states
   typedef enum logic [1:0] {ST_RX, ST_EXEC, ST_TX} nvscp_state_type;
endpackage : nvscp_pkg

// >>> nvscp_buf_if.sv
// carrier between the parser and its packet store
`timescale 1ns/1ps
interface nvscp_buf_if;
   logic we;                                  // byte write strobe
   logic [5:0] waddr;                         // byte index
   logic [7:0] wdata;                         // byte value
   logic [7:0] bytes [nvscp_pkg::PKT_LEN];    // whole stored packet
   modport writer (output we, waddr, wdata, input bytes);
   modport store (input we, waddr, wdata, output bytes);
endinterface : nvscp_buf_if

// >>> nvscp_pkt_buf.sv
// flip-flop store for one received command packet
`timescale 1ns/1ps
module nvscp_pkt_buf (
   input wire logic ref_clk,
   input wire logic rst_n,
   nvscp_buf_if.store bus
);
   import nvscp_pkg::*;

   logic [7:0] mem_reg [PKT_LEN];   // stored bytes
   logic [7:0] mem_next [PKT_LEN];

   // ==================================================
   // write one byte by index
   always_comb begin
      mem_next = mem_reg;
      if (bus.we) begin
         mem_next[bus.waddr] = bus.wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < PKT_LEN; i++) begin
            mem_reg[i] <= RST_BYTE;
         end
      end else begin
         mem_reg <= mem_next;
      end
   end

   assign bus.bytes = mem_reg;

   // ==================================================
   // checks
   AST_BUF_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      bus.we |=> mem_reg[$past(bus.waddr)] == $past(bus.wdata))
      else $error("packet byte not stored");
endmodule : nvscp_pkt_buf

// >>> nvscp_parser.sv
// power-up settings command parser: takes a 64-byte command, answers with 64 bytes
`timescale 1ns/1ps
module nvscp_parser (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_data,
   output logic cmd_ready,
   input wire logic rsp_ready,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic rsp_last,
   input wire logic pw_accepted,
   input wire logic spi_xfer_busy,
   output logic [31:0] nv_bit_rate,
   output logic [8:0] nv_idle_cs,
   output logic [8:0] nv_active_cs,
   output logic [15:0] nv_pre_delay,
   output logic [15:0] nv_post_delay,
   output logic [15:0] nv_gap_delay,
   output logic [15:0] nv_xfer_bytes,
   output logic [1:0] nv_spi_mode,
   output logic [15:0] nv_vendor_id,
   output logic [15:0] nv_product_id,
   output logic [7:0] nv_power_opt,
   output logic [7:0] nv_current,
   output logic [7:0] nv_access,
   output logic [63:0] nv_password,
   output logic str_we,
   output logic str_product,
   output logic [5:0] str_addr,
   output logic [7:0] str_data
);
   import nvscp_pkg::*;

   // ==================================================
   // helpers
   // two packet bytes as one little-endian half word
   function automatic logic [15:0] le16(input logic [7:0] lo, input logic [7:0] hi);
      return {hi, lo};
   endfunction : le16

   // ==================================================
   // packet store
   nvscp_buf_if pb ();
   nvscp_pkt_buf u_buf (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .bus(pb.store)
   );

   // ==================================================
   // state
   nvscp_state_type state_reg, state_next;   // sequencer
   logic [IDX_W-1:0] idx_reg, idx_next;      // byte counter
   logic [7:0] cmd_echo_reg, cmd_echo_next;  // response byte 0
   logic [7:0] status_reg, status_next;      // response byte 1
   logic [7:0] sub_echo_reg, sub_echo_next;  // response byte 2
   logic str_en_reg, str_en_next;            // descriptor bytes go out with the answer
   logic cmd_ready_reg, cmd_ready_next;
   logic rsp_valid_reg, rsp_valid_next;
   logic [7:0] rsp_data_reg, rsp_data_next;
   logic rsp_last_reg, rsp_last_next;
   logic str_we_reg, str_we_next;
   logic str_prod_reg, str_prod_next;
   logic [5:0] str_addr_reg, str_addr_next;
   logic [7:0] str_data_reg, str_data_next;
   // stored power-up settings
   logic [31:0] rate_reg, rate_next;
   logic [8:0] idle_reg, idle_next;
   logic [8:0] act_reg, act_next;
   logic [15:0] pre_reg, pre_next;
   logic [15:0] post_reg, post_next;
   logic [15:0] gap_reg, gap_next;
   logic [15:0] count_reg, count_next;
   logic [1:0] mode_reg, mode_next;
   logic [15:0] vid_reg, vid_next;
   logic [15:0] pid_reg, pid_next;
   logic [7:0] power_reg, power_next;
   logic [7:0] curr_reg, curr_next;
   logic [7:0] access_reg, access_next;
   logic [63:0] pw_reg, pw_next;

   // ==================================================
   // decoded fields of the held packet
   logic [31:0] f_rate;
   logic [63:0] f_pw;
   logic [7:0] f_cmd, f_sub;
   logic sub_known, blocked;

   assign f_cmd = pb.bytes[IX_CMD];
   assign f_sub = pb.bytes[IX_SUB];
   // bit rate arrives least significant byte first
   assign f_rate = {pb.bytes[IX_RATE+3], pb.bytes[IX_RATE+2],
                    pb.bytes[IX_RATE+1], pb.bytes[IX_RATE]};
   // first password character lands in the low byte
   always_comb begin
      f_pw = RST_PW;
      for (int i = 0; i < PW_LEN; i++) begin
         f_pw[i*8 +: 8] = pb.bytes[IX_PW+i];
      end
   end
   assign sub_known = (f_sub == SUB_SPI) || (f_sub == SUB_CHIP) || (f_sub == SUB_KEY) ||
                      (f_sub == SUB_MFR) || (f_sub == SUB_PROD);
   // a locked part never takes a write; a protected one only after the password
   assign blocked = (access_reg == ACC_LOCK) ||
                    ((access_reg == ACC_PW) && !pw_accepted);

   // ==================================================
   // next-state logic for sequencer, answer and store
   always_comb begin
      state_next = state_reg;
      idx_next = idx_reg;
      cmd_echo_next = cmd_echo_reg;
      status_next = status_reg;
      sub_echo_next = sub_echo_reg;
      str_en_next = str_en_reg;
      cmd_ready_next = cmd_ready_reg;
      rsp_valid_next = rsp_valid_reg;
      rsp_data_next = rsp_data_reg;
      rsp_last_next = rsp_last_reg;
      str_we_next = 1'b0;
      str_prod_next = str_prod_reg;
      str_addr_next = str_addr_reg;
      str_data_next = str_data_reg;
      rate_next = rate_reg;
      idle_next = idle_reg;
      act_next = act_reg;
      pre_next = pre_reg;
      post_next = post_reg;
      gap_next = gap_reg;
      count_next = count_reg;
      mode_next = mode_reg;
      vid_next = vid_reg;
      pid_next = pid_reg;
      power_next = power_reg;
      curr_next = curr_reg;
      access_next = access_reg;
      pw_next = pw_reg;
      pb.we = 1'b0;
      pb.waddr = idx_reg[5:0];
      pb.wdata = cmd_data;
      unique case (state_reg)
         // collect the 64 command bytes
         ST_RX: begin
            if (cmd_valid && cmd_ready_reg) begin
               pb.we = 1'b1;
               if (idx_reg == IX_LAST) begin
                  state_next = ST_EXEC;
                  cmd_ready_next = 1'b0;
                  idx_next = '0;
               end else begin
                  idx_next = idx_reg + 7'd1;
               end
            end
         end
         // judge the command and commit its settings in one cycle
         ST_EXEC: begin
            cmd_echo_next = f_cmd;
            status_next = STS_UNSUPP;
            sub_echo_next = 8'h00;
            str_en_next = 1'b0;
            if (f_cmd == CMD_SET_NV && sub_known) begin
               if (blocked) begin
                  status_next = STS_BLOCKED;
               end else if (f_sub == SUB_SPI && spi_xfer_busy) begin
                  status_next = STS_BUSY;
                  sub_echo_next = f_sub;
               end else begin
                  status_next = STS_OK;
                  sub_echo_next = f_sub;
                  if (f_sub == SUB_SPI) begin
                     rate_next = f_rate;
                     // only nine select lines exist, upper bits of the half word dropped
                     idle_next = 9'(le16(pb.bytes[IX_IDLE], pb.bytes[IX_IDLE+1]));
                     act_next = 9'(le16(pb.bytes[IX_ACT], pb.bytes[IX_ACT+1]));
                     pre_next = le16(pb.bytes[IX_PRE], pb.bytes[IX_PRE+1]);
                     post_next = le16(pb.bytes[IX_POST], pb.bytes[IX_POST+1]);
                     gap_next = le16(pb.bytes[IX_GAP], pb.bytes[IX_GAP+1]);
                     count_next = le16(pb.bytes[IX_COUNT], pb.bytes[IX_COUNT+1]);
                     mode_next = pb.bytes[IX_MODE][1:0];
                  end
                  if (f_sub == SUB_CHIP) begin
                     access_next = pb.bytes[IX_ACCESS];
                     // all-zero password field means keep the old one
                     if (f_pw != RST_PW) begin
                        pw_next = f_pw;
                     end
                  end
                  if (f_sub == SUB_KEY) begin
                     vid_next = le16(pb.bytes[IX_VID], pb.bytes[IX_VID+1]);
                     pid_next = le16(pb.bytes[IX_PID], pb.bytes[IX_PID+1]);
                     // reserved power bits are dropped, not trusted
                     power_next = pb.bytes[IX_POWER] & POWER_MASK;
                     curr_next = pb.bytes[IX_CURR];
                  end
                  if (f_sub == SUB_MFR || f_sub == SUB_PROD) begin
                     str_en_next = 1'b1;
                     str_prod_next = (f_sub == SUB_PROD);
                  end
               end
            end
            state_next = ST_TX;
         end
         // stream the answer; a stalled host holds the current byte
         ST_TX: begin
            if (!rsp_valid_reg || rsp_ready) begin
               if (idx_reg < IDX_W'(PKT_LEN)) begin
                  rsp_valid_next = 1'b1;
                  rsp_last_next = (idx_reg == IX_LAST);
                  if (idx_reg == 7'(IX_CMD)) begin
                     rsp_data_next = cmd_echo_reg;
                  end else if (idx_reg == 7'(IX_SUB)) begin
                     rsp_data_next = status_reg;
                  end else if (idx_reg == 7'(IX_ECHO)) begin
                     rsp_data_next = sub_echo_reg;
                  end else begin
                     rsp_data_next = 8'h00;
                  end
                  // descriptor bytes leave in step with the answer bytes
                  if (str_en_reg && idx_reg >= IX_STR) begin
                     str_we_next = 1'b1;
                     str_addr_next = 6'(idx_reg - IX_STR);
                     str_data_next = pb.bytes[idx_reg[5:0]];
                  end
                  idx_next = idx_reg + 7'd1;
               end else begin
                  // last byte taken: one answer per command, then listen again
                  rsp_valid_next = 1'b0;
                  rsp_last_next = 1'b0;
                  state_next = ST_RX;
                  cmd_ready_next = 1'b1;
                  idx_next = '0;
               end
            end
         end
      endcase
   end

   // ==================================================
   // registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_RX;
         idx_reg <= '0;
         cmd_echo_reg <= RST_BYTE;
         status_reg <= RST_BYTE;
         sub_echo_reg <= RST_BYTE;
         str_en_reg <= 1'b0;
         cmd_ready_reg <= 1'b1;
         rsp_valid_reg <= 1'b0;
         rsp_data_reg <= RST_BYTE;
         rsp_last_reg <= 1'b0;
         str_we_reg <= 1'b0;
         str_prod_reg <= 1'b0;
         str_addr_reg <= 6'h00;
         str_data_reg <= RST_BYTE;
         rate_reg <= RST_RATE;
         idle_reg <= RST_CS;
         act_reg <= RST_CS;
         pre_reg <= RST_HALF;
         post_reg <= RST_HALF;
         gap_reg <= RST_HALF;
         count_reg <= RST_HALF;
         mode_reg <= 2'h0;
         vid_reg <= RST_HALF;
         pid_reg <= RST_HALF;
         power_reg <= RST_BYTE;
         curr_reg <= RST_BYTE;
         access_reg <= RST_BYTE;
         pw_reg <= RST_PW;
      end else begin
         state_reg <= state_next;
         idx_reg <= idx_next;
         cmd_echo_reg <= cmd_echo_next;
         status_reg <= status_next;
         sub_echo_reg <= sub_echo_next;
         str_en_reg <= str_en_next;
         cmd_ready_reg <= cmd_ready_next;
         rsp_valid_reg <= rsp_valid_next;
         rsp_data_reg <= rsp_data_next;
         rsp_last_reg <= rsp_last_next;
         str_we_reg <= str_we_next;
         str_prod_reg <= str_prod_next;
         str_addr_reg <= str_addr_next;
         str_data_reg <= str_data_next;
         rate_reg <= rate_next;
         idle_reg <= idle_next;
         act_reg <= act_next;
         pre_reg <= pre_next;
         post_reg <= post_next;
         gap_reg <= gap_next;
         count_reg <= count_next;
         mode_reg <= mode_next;
         vid_reg <= vid_next;
         pid_reg <= pid_next;
         power_reg <= power_next;
         curr_reg <= curr_next;
         access_reg <= access_next;
         pw_reg <= pw_next;
      end
   end

   // ==================================================
   // outputs, all straight from flops
   assign cmd_ready = cmd_ready_reg;
   assign rsp_valid = rsp_valid_reg;
   assign rsp_data = rsp_data_reg;
   assign rsp_last = rsp_last_reg;
   assign str_we = str_we_reg;
   assign str_product = str_prod_reg;
   assign str_addr = str_addr_reg;
   assign str_data = str_data_reg;
   assign nv_bit_rate = rate_reg;
   assign nv_idle_cs = idle_reg;
   assign nv_active_cs = act_reg;
   assign nv_pre_delay = pre_reg;
   assign nv_post_delay = post_reg;
   assign nv_gap_delay = gap_reg;
   assign nv_xfer_bytes = count_reg;
   assign nv_spi_mode = mode_reg;
   assign nv_vendor_id = vid_reg;
   assign nv_product_id = pid_reg;
   assign nv_power_opt = power_reg;
   assign nv_current = curr_reg;
   assign nv_access = access_reg;
   assign nv_password = pw_reg;

   // ==================================================
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   logic exec_set;
   assign exec_set = (state_reg == ST_EXEC) && (f_cmd == CMD_SET_NV) && sub_known;

   AST_ECHO_CODE: assert property (
      exec_set |-> ##2 rsp_valid_reg && rsp_data_reg == CMD_SET_NV)
      else $error("command code not echoed first");
   AST_BLOCKED_KEEP: assert property (
      exec_set && blocked |=> status_reg == STS_BLOCKED && pw_reg == $past(pw_reg)
         && access_reg == $past(access_reg) && rate_reg == $past(rate_reg))
      else $error("blocked write changed settings");
   AST_CHIP_STORE: assert property (
      exec_set && !blocked && f_sub == SUB_CHIP |=> status_reg == STS_OK
         && sub_echo_reg == SUB_CHIP && access_reg == $past(pb.bytes[IX_ACCESS]))
      else $error("chip settings not stored");
   AST_SPI_BUSY: assert property (
      exec_set && !blocked && f_sub == SUB_SPI && spi_xfer_busy |=>
         status_reg == STS_BUSY && sub_echo_reg == SUB_SPI && rate_reg == $past(rate_reg))
      else $error("busy spi write not refused");
   AST_SPI_STORE: assert property (
      exec_set && !blocked && f_sub == SUB_SPI && !spi_xfer_busy |=>
         status_reg == STS_OK && rate_reg == $past(f_rate))
      else $error("spi settings not stored");
   AST_KEY_STORE: assert property (
      exec_set && !blocked && f_sub == SUB_KEY |=>
         vid_reg == {$past(pb.bytes[IX_VID+1]), $past(pb.bytes[IX_VID])})
      else $error("vendor id not stored");
   AST_NO_RX_IN_TX: assert property (
      rsp_valid_reg |-> !cmd_ready_reg)
      else $error("command taken while answering");
   AST_RX_AFTER_LAST: assert property (
      rsp_valid_reg && rsp_last_reg && rsp_ready |=> cmd_ready_reg && !rsp_valid_reg)
      else $error("no return to receive after last byte");
   AST_ZERO_FILL: assert property (
      rsp_valid_reg && idx_reg > 7'd3 |-> rsp_data_reg == 8'h00)
      else $error("unused response byte not zero");
   AST_STR_OK: assert property (
      str_we_reg |-> rsp_valid_reg && status_reg == STS_OK)
      else $error("descriptor written without success");

   COV_BLOCKED: cover property (exec_set && blocked);
   COV_BUSY: cover property (exec_set && f_sub == SUB_SPI && spi_xfer_busy && !blocked);
   COV_STR: cover property (str_we_reg && str_addr_reg == 6'h00);
   COV_DONE: cover property (rsp_valid_reg && rsp_last_reg && rsp_ready);
endmodule : nvscp_parser

// >>> nvscp_host.sv
// host model: sends one command packet, collects its response packet
`timescale 1ns/1ps
module nvscp_host (
   input wire logic ref_clk,
   input wire logic cmd_ready,
   output logic cmd_valid,
   output logic [7:0] cmd_data,
   output logic rsp_ready,
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_data,
   input wire logic rsp_last
);
   // ==================================================
   // collected response
   logic [7:0] rsp [64]; // response bytes in order taken
   int got; // bytes taken
   int last_at; // index where the last flag was seen
   initial begin
      cmd_valid = 1'b0;
      cmd_data = 8'h00;
      rsp_ready = 1'b0;
   end
   // caller enters just after a clock edge; each byte held until taken
   task automatic xfer(input logic [7:0] p [64]);
      int k;
      got = 0;
      last_at = -1;
      for (k = 0; k < 64; k++) begin
         cmd_valid <= 1'b1;
         cmd_data <= p[k];
         @(posedge ref_clk);
         while (cmd_ready !== 1'b1) @(posedge ref_clk);
      end
      cmd_valid <= 1'b0;
      cmd_data <= ~p[63]; // released line must not look like valid data
      rsp_ready <= 1'b1;
      for (k = 0; k < 300 && got < 64; k++) begin
         @(posedge ref_clk);
         if (rsp_valid === 1'b1) begin
            if (rsp_last === 1'b1) last_at = got;
            rsp[got] = rsp_data;
            got++;
         end
      end
      rsp_ready <= 1'b0;
   endtask : xfer
endmodule : nvscp_host

// >>> tb.sv
// self-checking bench for the power-up settings command parser
`timescale 1ns/1ps
module tb;
   import nvscp_pkg::*;
   logic ref_clk, rst_n, pw_accepted, spi_xfer_busy, cmd_valid, cmd_ready;
   logic rsp_ready, rsp_valid, rsp_last, str_we, str_product;
   logic [7:0] cmd_data, rsp_data, nv_power_opt, nv_current, nv_access, str_data;
   logic [8:0] nv_idle_cs, nv_active_cs;
   logic [15:0] nv_pre_delay, nv_post_delay, nv_gap_delay, nv_xfer_bytes;
   logic [15:0] nv_vendor_id, nv_product_id;
   logic [31:0] nv_bit_rate, old_rate;
   logic [1:0] nv_spi_mode;
   logic [63:0] nv_password, pw_exp;
   logic [5:0] str_addr;
   logic [7:0] pkt [64]; // packet under construction
   int bad_count, compares, str_cnt, str_err, m, k;
   nvscp_parser i_nvscp_parser (.ref_clk, .rst_n, .cmd_valid, .cmd_data, .cmd_ready,
      .rsp_ready, .rsp_valid, .rsp_data, .rsp_last, .pw_accepted, .spi_xfer_busy,
      .nv_bit_rate, .nv_idle_cs, .nv_active_cs, .nv_pre_delay, .nv_post_delay,
      .nv_gap_delay, .nv_xfer_bytes, .nv_spi_mode, .nv_vendor_id, .nv_product_id,
      .nv_power_opt, .nv_current, .nv_access, .nv_password, .str_we, .str_product,
      .str_addr, .str_data);
   nvscp_host i_nvscp_host (.ref_clk, .cmd_ready, .cmd_valid, .cmd_data, .rsp_ready,
      .rsp_valid, .rsp_data, .rsp_last);
   // ==================================================
   // clock, descriptor stream monitor
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (str_we === 1'b1) begin
         str_cnt++;
         if (str_data !== pkt[str_addr + 4]) str_err++; // byte must match its packet slot
      end
   end
   // ==================================================
   // compare, packet and command tasks
   task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp
   task automatic newpkt(input logic [7:0] sub);
      foreach (pkt[i]) pkt[i] = 8'h00; // reserved and password bytes zero
      pkt[0] = CMD_SET_NV;
      pkt[1] = sub;
   endtask : newpkt
   // one full command, then the response checked byte by byte
   task automatic run(input logic pw, input logic busy, input logic [7:0] sts, echo);
      @(posedge ref_clk);
      pw_accepted <= pw;
      spi_xfer_busy <= busy;
      i_nvscp_host.xfer(pkt);
      for (int i = 0; i < 64; i++)
         cmp("rsp byte", (i == 0) ? 8'h60 : (i == 1) ? sts : (i == 2) ? echo : 8'h00,
             i_nvscp_host.rsp[i]);
      cmp("rsp count", 64, i_nvscp_host.got);
      cmp("last index", 63, i_nvscp_host.last_at);
      repeat (3) @(posedge ref_clk);
      cmp("extra rsp", 0, rsp_valid);
   endtask : run
   task automatic summarize();
      $display("counts: compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize
   // ==================================================
   // watchdog: whole run needs about 7.5 us
   initial begin
      #200000;
      bad_count++;
      summarize();
   end
   // ==================================================
   // test sequence
   initial begin
      rst_n = 1'b0;
      pw_accepted = 1'b0;
      spi_xfer_busy = 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      cmp("reset access", RST_BYTE, nv_access);
      cmp("reset password", RST_PW, nv_password);
      for (m = 0; m < 4; m++) begin // every spi mode once
         newpkt(SUB_SPI);
         for (k = 4; k < 20; k++) pkt[k] = 8'(k * 7 + m);
         pkt[20] = 8'(m);
         run(1'b0, 1'b0, STS_OK, SUB_SPI);
         cmp("rate", {pkt[7], pkt[6], pkt[5], pkt[4]}, nv_bit_rate);
         cmp("idle cs", {pkt[9][0], pkt[8]}, nv_idle_cs);
         cmp("active cs", {pkt[11][0], pkt[10]}, nv_active_cs);
         cmp("pre", {pkt[13], pkt[12]}, nv_pre_delay);
         cmp("post", {pkt[15], pkt[14]}, nv_post_delay);
         cmp("gap", {pkt[17], pkt[16]}, nv_gap_delay);
         cmp("count", {pkt[19], pkt[18]}, nv_xfer_bytes);
         cmp("mode", m, nv_spi_mode);
         $display("test spi write mode %0d done", m);
      end
      old_rate = {pkt[7], pkt[6], pkt[5], pkt[4]};
      pkt[4] = ~pkt[4];
      run(1'b0, 1'b1, STS_BUSY, SUB_SPI);
      cmp("rate kept", old_rate, nv_bit_rate);
      $display("test busy done");
      newpkt(SUB_KEY);
      {pkt[5], pkt[4], pkt[7], pkt[6]} = 32'h1234_5678;
      pkt[8] = 8'h9f; // one power source bit set
      pkt[9] = 8'h32;
      run(1'b0, 1'b0, STS_OK, SUB_KEY);
      cmp("vid", 16'h1234, nv_vendor_id);
      cmp("pid", 16'h5678, nv_product_id);
      cmp("power", 8'h80, nv_power_opt);
      cmp("current", 8'h32, nv_current);
      $display("test key done");
      for (m = 0; m < 2; m++) begin // manufacturer then product string
         newpkt(m ? SUB_PROD : SUB_MFR);
         pkt[4] = 8'h3e; // 30 chars * 2 + 2
         pkt[5] = 8'h03;
         for (k = 6; k < 64; k++) pkt[k] = 8'(k);
         str_cnt = 0;
         str_err = 0;
         run(1'b0, 1'b0, STS_OK, m ? SUB_PROD : SUB_MFR);
         cmp("str bytes", 60, str_cnt);
         cmp("str data", 0, str_err);
         cmp("str product", m, str_product);
         $display("test string %0d done", m);
      end
      newpkt(SUB_CHIP);
      pkt[18] = ACC_PW;
      for (k = 0; k < 8; k++) pkt[19 + k] = 8'(8'h41 + k);
      for (k = 0; k < 8; k++) pw_exp[8 * k +: 8] = pkt[19 + k];
      run(1'b0, 1'b0, STS_OK, SUB_CHIP);
      cmp("access", ACC_PW, nv_access);
      cmp("password", pw_exp, nv_password);
      newpkt(SUB_SPI);
      pkt[4] = 8'hee;
      run(1'b0, 1'b0, STS_BLOCKED, 8'h00);
      cmp("rate blocked", old_rate, nv_bit_rate);
      newpkt(SUB_MFR);
      str_cnt = 0;
      run(1'b0, 1'b0, STS_BLOCKED, 8'h00);
      cmp("str blocked", 0, str_cnt);
      newpkt(SUB_CHIP); // password bytes left zero
      pkt[18] = ACC_LOCK;
      run(1'b1, 1'b0, STS_OK, SUB_CHIP);
      cmp("access lock", ACC_LOCK, nv_access);
      cmp("password kept", pw_exp, nv_password);
      newpkt(SUB_KEY);
      pkt[4] = 8'h99;
      run(1'b1, 1'b0, STS_BLOCKED, 8'h00);
      cmp("vid locked", 16'h1234, nv_vendor_id);
      $display("test protection done");
      newpkt(8'h77); // sub-command the parser does not know
      pkt[4] = 8'h55;
      run(1'b1, 1'b0, STS_UNSUPP, 8'h00);
      cmp("vid unsupported", 16'h1234, nv_vendor_id);
      $display("test unsupported done");
      summarize();
   end
endmodule : tb
